// ===== hdl/iod_defs.vh
// Constants for the instruction operand field decoder.
// Assumes a 16-bit instruction word and a 32-bit classic Wishbone slave port.
`ifndef IOD_DEFS_VH
`define IOD_DEFS_VH

// Instruction cycle: oscillator periods per cycle
`define IOD_QPH_W        2
`define IOD_QPH_LAST     2'h3

// Register byte offsets
`define IOD_ADR_W        5
`define IOD_OFS_BANK     5'h00
`define IOD_OFS_TPTR     5'h04
`define IOD_OFS_TLAT     5'h08
`define IOD_OFS_FSR0     5'h0c
`define IOD_OFS_FSR3     5'h18
`define IOD_OFS_STAT     5'h1c

// Reset values
`define IOD_BANK_RST     4'h0
`define IOD_TPTR_RST     21'h000000
`define IOD_TLAT_RST     8'h00
`define IOD_FSR_RST      12'h000

// Access RAM split: low part in bank 0, high part in the top bank
`define IOD_ACC_SPLIT    8'h60
`define IOD_BANK_LOW     4'h0
`define IOD_BANK_TOP     4'hf

// Second word marker in the top nibble
`define IOD_WORD2_TAG    4'hf

// Opcode patterns
`define IOD_OP_MOVFF     4'hc
`define IOD_OP_BRA       4'hd
`define IOD_OP_LIT8      5'h01
`define IOD_OP_TBL       13'h0001
`define IOD_OP_RET       15'h0009
`define IOD_OP_CALL      7'h76
`define IOD_OP_GOTO      8'hef
`define IOD_OP_LFSR      10'h3b8
`define IOD_OP_MOVSX     8'heb
`define IOD_OP_ADDFSR    8'he8
`define IOD_OP_BCC       5'h1c

// Table pointer update modes
`define IOD_TM_NONE      2'h0
`define IOD_TM_POSTINC   2'h1
`define IOD_TM_POSTDEC   2'h2
`define IOD_TM_PREINC    2'h3

// Literal width codes
`define IOD_LW_NONE      2'h0
`define IOD_LW_8         2'h1
`define IOD_LW_12        2'h2
`define IOD_LW_20        2'h3

// Flag mask bit order {negative, overflow, zero, digit carry, carry}
`define IOD_FL_ALL       5'h1f
`define IOD_FL_ZN        5'h14
`define IOD_FL_CZN       5'h15
`define IOD_FL_Z         5'h04
`define IOD_FL_NONE      5'h00

`endif

// ===== hdl/iod_decoder.v
// Operand field decoder for 16-bit core instruction words, with its
// bank, table pointer, table latch and indirect pointer registers.
// Assumes fetch and datapath run on the same clock; registers over Wishbone.
// Functional notes
// (RL1) a=0 targets access RAM, bank ignored
// (RL2) a=1 uses bank number register
// (RL3) d=0 writes result to accumulator
// (RL4) d=1 writes result to file register
// (RL5) Three-bit index selects bit 0..7
// (RL6) File field: 8-bit address or pointer select
// (RL7) Move carries full 12-bit source, destination
// (RL8) Four table pointer update modes applied
// (RL9) Fast bit saves/restores shadows, else untouched
// (RL10) Table pointer 21 bits, latch 8 bits
// (RL11) Displacement signed relative, or absolute target
// (RL12) Literal extracted as 8, 12, 20 bits
// (RL13) Indexed 7-bit offsets added to pointer
// (RL14) Don't-care bits never affect decoding
// (RL15) Report which arithmetic flags are updated
// (RL16) Lone second word executes as no-op
// (RL17) Four periods per cycle, flush adds no-op
// (RL18) Fields latched at accept, held until next
`include "iod_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module iod_decoder (
  input  wire        clock,
  input  wire        rst_n,
  // Fetch path
  input  wire [15:0] instr_word,
  input  wire        instr_valid,
  output wire        instr_ready,
  input  wire [20:0] pc_value,
  input  wire        flow_change,
  // Datapath return
  input  wire        tbl_data_valid,
  input  wire [7:0]  tbl_data,
  // Decoded fields
  output reg         dec_valid,
  output reg         dec_nop,
  output reg  [11:0] ram_addr,
  output reg         dest_to_file,
  output reg         dest_to_accum,
  output reg  [7:0]  bit_mask,
  output reg  [1:0]  ptr_sel,
  output reg  [11:0] move_src_addr,
  output reg  [11:0] move_dst_addr,
  output reg  [19:0] literal_value,
  output reg  [1:0]  literal_width,
  output reg  [20:0] branch_target,
  output reg         branch_valid,
  output reg  [11:0] indexed_src_addr,
  output reg  [11:0] indexed_dst_addr,
  output reg  [20:0] table_access_addr,
  output reg         table_access,
  output reg         table_write,
  output reg         shadow_save,
  output reg         shadow_restore,
  output reg  [4:0]  flag_update_mask,
  output wire [7:0]  program_table_latch,
  // Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [31:0] wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o
);

  localparam [2:0] ST_FIRST  = 3'b001;
  localparam [2:0] ST_SECOND = 3'b010;
  localparam [2:0] ST_FLUSH  = 3'b100;

  reg        rst_s1_q;
  reg        rst_s2_q;
  wire       rst_l_n;
  reg  [`IOD_QPH_W-1:0] qph_q;
  reg  [2:0]  state_q;
  reg  [15:0] word1_q;
  reg  [3:0]  bank_number_register_q;
  reg  [20:0] program_table_pointer_q;
  reg  [7:0]  program_table_latch_q;
  reg  [11:0] indirect_pointer_q [0:3];
  wire        cycle_en;
  wire        accept;
  wire        wb_req;
  wire        wb_map;
  wire        has_d;
  wire [31:0] wmask;
  wire [`IOD_ADR_W-1:0] wofs;
  wire        is_byte;
  wire        is_bit;
  wire        is_two;
  wire [7:0]  ffld;
  wire [11:0] bank_addr;
  wire [11:0] acc_addr;
  integer     i;

  // Reset release through two flops
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rst_l_n = rst_s2_q;

  // Oscillator phase counter, one instruction cycle per wrap
  always @(posedge clock or negedge rst_l_n) begin
    if (!rst_l_n) qph_q <= {`IOD_QPH_W{1'b0}};
    else qph_q <= qph_q + 1'b1; // RL17
  end
  assign cycle_en    = (qph_q == `IOD_QPH_LAST); // RL17
  assign instr_ready = cycle_en;
  assign accept      = cycle_en & instr_valid;

  // Instruction classes from the word being accepted
  assign is_byte = ((instr_word[15:12] >= 4'h1) && (instr_word[15:12] <= 4'h6)) ||
                   (instr_word[15:10] == 6'h01) || (instr_word[15:9] == 7'h01);
  assign is_bit  = (instr_word[15:12] >= 4'h7) && (instr_word[15:12] <= 4'hb);
  // Byte ops that carry a destination bit (not the 0110 group or multiply)
  assign has_d   = is_byte && (instr_word[15:12] != 4'h6) && (instr_word[15:9] != 7'h01);
  assign is_two  = (instr_word[15:12] == `IOD_OP_MOVFF) ||
                   (instr_word[15:9] == `IOD_OP_CALL) ||
                   (instr_word[15:8] == `IOD_OP_GOTO) ||
                   (instr_word[15:6] == `IOD_OP_LFSR) ||
                   (instr_word[15:8] == `IOD_OP_MOVSX);
  assign ffld      = instr_word[7:0];
  assign bank_addr = {bank_number_register_q, ffld}; // RL2
  assign acc_addr  = (ffld < `IOD_ACC_SPLIT) ? {`IOD_BANK_LOW, ffld}
                                             : {`IOD_BANK_TOP, ffld}; // RL1

  // Flags written by each byte operation
  function [4:0] flag_mask;
    input [15:0] w;
    begin
      case (w[15:10])
        6'h09, 6'h08, 6'h15, 6'h16, 6'h17, 6'h01, 6'h0a: flag_mask = `IOD_FL_ALL;
        6'h05, 6'h07, 6'h04, 6'h14, 6'h06, 6'h11, 6'h10: flag_mask = `IOD_FL_ZN;
        6'h0d, 6'h0c:                                    flag_mask = `IOD_FL_CZN;
        6'h1a: flag_mask = (w[9]) ? `IOD_FL_Z : `IOD_FL_NONE; // clear or set
        6'h1b: flag_mask = (w[9]) ? `IOD_FL_NONE : `IOD_FL_ALL; // move or negate
        default:                                         flag_mask = `IOD_FL_NONE;
      endcase
    end
  endfunction

  // Sequencer and decoded field latch, held until the next accept except the one-cycle dec_valid, table_access and shadow strobes
  always @(posedge clock or negedge rst_l_n) begin
    if (!rst_l_n) begin
      state_q <= ST_FIRST;
      word1_q <= 16'h0000;
      dec_valid <= 1'b0;
      dec_nop <= 1'b1;
      ram_addr <= 12'h000;
      dest_to_file <= 1'b0;
      dest_to_accum <= 1'b0;
      bit_mask <= 8'h00;
      ptr_sel <= 2'h0;
      move_src_addr <= 12'h000;
      move_dst_addr <= 12'h000;
      literal_value <= 20'h00000;
      literal_width <= `IOD_LW_NONE;
      branch_target <= 21'h000000;
      branch_valid <= 1'b0;
      indexed_src_addr <= 12'h000;
      indexed_dst_addr <= 12'h000;
      table_access_addr <= `IOD_TPTR_RST;
      table_access <= 1'b0;
      table_write <= 1'b0;
      shadow_save <= 1'b0;
      shadow_restore <= 1'b0;
      flag_update_mask <= `IOD_FL_NONE;
    end else begin
      dec_valid <= accept;
      table_access <= 1'b0;
      shadow_save <= 1'b0;
      shadow_restore <= 1'b0;
      if (accept) begin // RL18
        dec_nop <= 1'b1;
        dest_to_file <= 1'b0;
        dest_to_accum <= 1'b0;
        branch_valid <= 1'b0;
        literal_width <= `IOD_LW_NONE;
        flag_update_mask <= `IOD_FL_NONE;
        table_write <= 1'b0;
        case (state_q)
          ST_FLUSH: begin
            state_q <= ST_FIRST; // RL17
          end
          ST_SECOND: begin
            state_q <= ST_FIRST;
            if (instr_word[15:12] == `IOD_WORD2_TAG) begin
              dec_nop <= 1'b0;
              if (word1_q[15:12] == `IOD_OP_MOVFF) begin
                move_src_addr <= word1_q[11:0]; // RL7
                move_dst_addr <= instr_word[11:0]; // RL7
              end else if (word1_q[15:6] == `IOD_OP_LFSR) begin
                ptr_sel <= word1_q[5:4];
                literal_value <= {8'h00, word1_q[3:0], instr_word[7:0]}; // RL12
                literal_width <= `IOD_LW_12;
              end else if (word1_q[15:8] == `IOD_OP_MOVSX) begin
                // With word1_q bit 7 set, second word bits above the offset are ignored
                indexed_src_addr <= indirect_pointer_q[2] + {5'h00, word1_q[6:0]}; // RL13
                indexed_dst_addr <= word1_q[7] ?
                  indirect_pointer_q[2] + {5'h00, instr_word[6:0]} : instr_word[11:0]; // RL14
              end else begin
                literal_value <= {instr_word[11:0], word1_q[7:0]}; // RL12
                literal_width <= `IOD_LW_20;
                branch_target <= {instr_word[11:0], word1_q[7:0], 1'b0}; // RL11
                branch_valid <= 1'b1;
                if (word1_q[15:9] == `IOD_OP_CALL) begin
                  shadow_save <= word1_q[8]; // RL9
                end
              end
            end
            if (flow_change) state_q <= ST_FLUSH;
          end
          default: begin
            state_q <= flow_change ? ST_FLUSH : ST_FIRST; // RL17
            word1_q <= instr_word;
            if (instr_word[15:12] == `IOD_WORD2_TAG) begin
              dec_nop <= 1'b1; // RL16
            end else if (is_two) begin
              state_q <= ST_SECOND;
            end else begin
              dec_nop <= 1'b0;
              if (is_byte || is_bit) begin
                ram_addr <= instr_word[8] ? bank_addr : acc_addr; // RL1 RL2
                ptr_sel <= ffld[1:0]; // RL6
              end
              if (has_d) begin
                dest_to_file  <= instr_word[9]; // RL4
                dest_to_accum <= ~instr_word[9]; // RL3
              end
              if (is_byte) begin
                flag_update_mask <= flag_mask(instr_word); // RL15
              end
              if (is_bit) begin
                bit_mask <= 8'h01 << instr_word[11:9]; // RL5
              end
              if (instr_word[15:11] == `IOD_OP_LIT8) begin
                literal_value <= {12'h000, ffld}; // RL12
                literal_width <= `IOD_LW_8;
              end
              if (instr_word[15:8] == `IOD_OP_ADDFSR) begin
                ptr_sel <= ffld[7:6]; // RL6
                literal_value <= {14'h0000, ffld[5:0]};
                literal_width <= `IOD_LW_8;
              end
              if (instr_word[15:12] == `IOD_OP_BRA) begin
                branch_target <= pc_value + 21'h000002 +
                  {{9{instr_word[10]}}, instr_word[10:0], 1'b0}; // RL11
                branch_valid <= 1'b1;
              end
              if (instr_word[15:11] == `IOD_OP_BCC) begin
                branch_target <= pc_value + 21'h000002 +
                  {{12{instr_word[7]}}, instr_word[7:0], 1'b0}; // RL11
                branch_valid <= 1'b1;
              end
              if (instr_word[15:3] == `IOD_OP_TBL) begin
                table_access <= 1'b1;
                table_write <= instr_word[2]; // RL8
                table_access_addr <= (instr_word[1:0] == `IOD_TM_PREINC) ?
                  program_table_pointer_q + 21'h000001 : program_table_pointer_q; // RL8
              end
              if (instr_word[15:1] == `IOD_OP_RET) begin
                shadow_restore <= instr_word[0]; // RL9
              end
            end
          end
        endcase
      end
    end
  end

  // Table group covers read and write; low two bits pick the pointer mode
  wire tbl_op   = accept & (state_q == ST_FIRST) & (instr_word[15:3] == `IOD_OP_TBL);
  wire [1:0] tbl_mode = instr_word[1:0];

  // Byte-lane mask and aligned register offset for Wishbone
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wmask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wofs   = {wb_adr_i[`IOD_ADR_W-1:2], 2'b00};
  // Upper address bits must be zero, else the access is unmapped
  assign wb_map = (wb_adr_i[31:`IOD_ADR_W] == {(32-`IOD_ADR_W){1'b0}});

  // Registers: hardware updates win over a software write in the same cycle
  always @(posedge clock or negedge rst_l_n) begin
    if (!rst_l_n) begin
      bank_number_register_q  <= `IOD_BANK_RST;
      program_table_pointer_q <= `IOD_TPTR_RST;
      program_table_latch_q   <= `IOD_TLAT_RST;
      for (i = 0; i < 4; i = i + 1) indirect_pointer_q[i] <= `IOD_FSR_RST;
    end else begin
      if (wb_req && wb_we_i && wb_map) begin
        case (wofs)
          `IOD_OFS_BANK: bank_number_register_q <=
            (bank_number_register_q & ~wmask[3:0]) | (wb_dat_i[3:0] & wmask[3:0]);
          `IOD_OFS_TPTR: program_table_pointer_q <=
            (program_table_pointer_q & ~wmask[20:0]) | (wb_dat_i[20:0] & wmask[20:0]);
          `IOD_OFS_TLAT: program_table_latch_q <=
            (program_table_latch_q & ~wmask[7:0]) | (wb_dat_i[7:0] & wmask[7:0]);
          default: begin
            if (wofs >= `IOD_OFS_FSR0 && wofs <= `IOD_OFS_FSR3)
              indirect_pointer_q[wofs[3:2] - 2'h3] <=
                (indirect_pointer_q[wofs[3:2] - 2'h3] & ~wmask[11:0]) |
                (wb_dat_i[11:0] & wmask[11:0]);
          end
        endcase
      end
      if (tbl_op) begin
        case (tbl_mode)
          `IOD_TM_POSTINC: program_table_pointer_q <= program_table_pointer_q + 21'h000001;
          `IOD_TM_POSTDEC: program_table_pointer_q <= program_table_pointer_q - 21'h000001;
          `IOD_TM_PREINC:  program_table_pointer_q <= program_table_pointer_q + 21'h000001;
          default:         program_table_pointer_q <= program_table_pointer_q; // RL8
        endcase
      end
      if (tbl_data_valid) program_table_latch_q <= tbl_data; // RL10
    end
  end
  assign program_table_latch = program_table_latch_q;

  // Wishbone answer one cycle after the request, read data with it
  always @(posedge clock or negedge rst_l_n) begin
    if (!rst_l_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h00000000;
      if (wb_req && !wb_we_i && wb_map) begin
        case (wofs)
          `IOD_OFS_BANK: wb_dat_o <= {28'h0000000, bank_number_register_q};
          `IOD_OFS_TPTR: wb_dat_o <= {11'h000, program_table_pointer_q};
          `IOD_OFS_TLAT: wb_dat_o <= {24'h000000, program_table_latch_q};
          `IOD_OFS_STAT: wb_dat_o <= {24'h000000, flag_update_mask, state_q};
          default: begin
            if (wofs >= `IOD_OFS_FSR0 && wofs <= `IOD_OFS_FSR3)
              wb_dat_o <= {20'h00000, indirect_pointer_q[wofs[3:2] - 2'h3]};
          end
        endcase
      end
    end
  end

endmodule // iod_decoder

`default_nettype wire

// ===== tb/iod_chk.sv
// Port timing checker for the operand decoder.
// Assumes it is bound to iod_decoder and shares its single clock.
`timescale 1ns/1ps
`default_nettype none
module iod_chk (
  input wire logic       clock,
  input wire logic       rst_n,
  input wire logic       instr_valid,
  input wire logic       instr_ready,
  input wire logic       dec_valid,
  input wire logic [11:0] ram_addr,
  input wire logic       dest_to_file,
  input wire logic       dest_to_accum,
  input wire logic [7:0] bit_mask,
  input wire logic       shadow_save,
  input wire logic       shadow_restore,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Word taken by the decoder
  wire acc = instr_valid && instr_ready;
  AST_READY_GAP: assert property (instr_ready |=> !instr_ready [*3] ##1 instr_ready)
    else $error("ready not one cycle in four");
  AST_DEC_AFTER: assert property (acc |=> dec_valid)
    else $error("no decode after accept");
  AST_DEC_CAUSE: assert property (dec_valid |-> $past(acc))
    else $error("decode without accept");
  AST_FIELD_HOLD: assert property (!acc |=> $stable(ram_addr) && $stable(bit_mask))
    else $error("fields moved between accepts");
  AST_DEST_EXCL: assert property (!(dest_to_file && dest_to_accum))
    else $error("both destinations set");
  AST_BIT_ONEHOT: assert property ($onehot0(bit_mask))
    else $error("bit mask not one-hot");
  AST_SHADOW_PULSE: assert property ((shadow_save || shadow_restore) |->
    !(shadow_save && shadow_restore) ##1 !(shadow_save || shadow_restore))
    else $error("shadow strobe malformed");
  AST_ACK_LAT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus ack late");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus ack held");
  // Main scenarios seen
  cover property (acc);
  cover property (shadow_save);
  cover property (shadow_restore);
  cover property (wb_ack_o);
endmodule // iod_chk

bind iod_decoder iod_chk iod_chk_i (.clock(clock), .rst_n(rst_n), .instr_valid(instr_valid),
  .instr_ready(instr_ready), .dec_valid(dec_valid), .ram_addr(ram_addr),
  .dest_to_file(dest_to_file), .dest_to_accum(dest_to_accum), .bit_mask(bit_mask),
  .shadow_save(shadow_save), .shadow_restore(shadow_restore), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o));
`default_nettype wire

// ===== tb/iod_fetch_model.sv
// Fetch path and program table memory standing beside the decoder.
// Assumes the bench calls offer() once the previous call has returned.
`timescale 1ns/1ps
`default_nettype none
module iod_fetch_model (
  input  wire logic        clock,
  input  wire logic        instr_ready,
  input  wire logic        table_access,
  input  wire logic        table_write,
  input  wire logic [20:0] table_access_addr,
  output var  logic [15:0] instr_word,
  output var  logic        instr_valid,
  output var  logic        tbl_data_valid,
  output var  logic [7:0]  tbl_data
);
  initial begin
    instr_word = 16'h0000;
    instr_valid = 1'b0;
    tbl_data_valid = 1'b0;
    tbl_data = 8'h00;
  end
  // Hold a word until taken; idle bus shows the inverse
  task automatic offer(input logic [15:0] w);
    @(posedge clock);
    instr_valid <= 1'b1;
    instr_word <= w;
    do @(posedge clock); while (instr_ready !== 1'b1);
    instr_valid <= 1'b0;
    instr_word <= ~w;
  endtask
  // Table memory answers one cycle after a read; writes get no answer
  always @(posedge clock) begin
    tbl_data_valid <= table_access & ~table_write;
    tbl_data <= table_access ? (table_access_addr[7:0] ^ 8'h5a) : ~tbl_data;
  end
endmodule // iod_fetch_model
`default_nettype wire

// ===== tb/tb_iod_decoder.sv
// Self-checking bench for the operand decoder.
// Assumes iod_fetch_model as fetch path and iod_chk bound to the design.
`timescale 1ns/1ps
`default_nettype none
module tb_iod_decoder;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic [20:0] pc_value = 21'h0;
  logic        flow_change = 1'b0;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, rd;
  logic [3:0]  wb_sel_i = 4'h0;
  wire  [15:0] instr_word;
  wire         instr_valid, instr_ready, tbl_data_valid, dec_valid, dec_nop, dest_to_file;
  wire         dest_to_accum, branch_valid, table_access, shadow_save, shadow_restore, wb_ack_o;
  wire         table_write;
  wire  [7:0]  tbl_data, bit_mask, program_table_latch;
  wire  [11:0] ram_addr, move_src_addr, move_dst_addr, indexed_src_addr, indexed_dst_addr;
  wire  [19:0] literal_value;
  wire  [1:0]  literal_width, ptr_sel;
  wire  [20:0] branch_target, table_access_addr;
  wire  [4:0]  flag_update_mask;
  wire  [31:0] wb_dat_o;
  int          n_errors = 0, check_count = 0, cyc = 0;
  iod_decoder iod_decoder_i (.clock, .rst_n, .instr_word, .instr_valid, .instr_ready,
    .pc_value, .flow_change, .tbl_data_valid, .tbl_data, .dec_valid, .dec_nop, .ram_addr,
    .dest_to_file, .dest_to_accum, .bit_mask, .ptr_sel, .move_src_addr, .move_dst_addr,
    .literal_value, .literal_width, .branch_target, .branch_valid, .indexed_src_addr,
    .indexed_dst_addr, .table_access_addr, .table_access, .table_write, .shadow_save,
    .shadow_restore, .flag_update_mask, .program_table_latch, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o);
  iod_fetch_model iod_fetch_model_i (.clock, .instr_ready, .table_access, .table_write,
    .table_access_addr, .instr_word, .instr_valid, .tbl_data_valid, .tbl_data);
  always #2.5 clock = ~clock;
  // Hang guard
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_errors = n_errors + 1;
      finish_test();
    end
  end
  task automatic finish_test();
    if (n_errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [20:0] got, input logic [20:0] exp);
    check_count = check_count + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One classic bus cycle, read data kept in rd
  task automatic wb(input logic we, input logic [31:0] a, input logic [31:0] d);
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    do @(posedge clock); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  // Issue one word, then settle for checks
  task automatic go(input logic [15:0] w, input logic fc);
    @(posedge clock);
    flow_change <= fc;
    iod_fetch_model_i.offer(w);
    flow_change <= 1'b0;
    @(negedge clock);
  endtask
  task automatic t_regs();
    wb(1'b0, 32'h00, 32'h0);
    chk(rd[20:0], 21'h0);
    wb(1'b1, 32'h04, 32'hffffffff);
    wb(1'b0, 32'h04, 32'h0);
    chk(rd[20:0], 21'h1fffff);
    wb(1'b1, 32'h00, 32'h5);
    wb(1'b0, 32'h40, 32'h0);
    chk(rd[20:0], 21'h0);
    wb(1'b0, 32'h00, 32'h0);
    chk(rd[20:0], 21'h5);
  endtask
  task automatic t_byte();
    go(16'h2410, 1'b0);
    chk(21'(ram_addr), 21'h010);
    chk({dest_to_accum, dest_to_file}, 21'h2);
    chk(21'(flag_update_mask), 21'h1f);
    go(16'h2480, 1'b0);
    chk(21'(ram_addr), 21'hf80);
    go(16'h1723, 1'b0);
    chk(21'(ram_addr), 21'h523);
    chk({dest_to_accum, dest_to_file}, 21'h1);
    chk(21'(flag_update_mask), 21'h14);
    go(16'h6a10, 1'b0);
    chk(21'(flag_update_mask), 21'h04);
    chk({dest_to_accum, dest_to_file}, 21'h0);
  endtask
  task automatic t_bits();
    for (int b = 0; b < 8; b++) begin
      go({4'h8, 3'(b), 9'h030}, 1'b0);
      chk(21'(bit_mask), 21'(8'h01 << b));
    end
  endtask
  task automatic t_words();
    go(16'hc123, 1'b0);
    go(16'hf456, 1'b0);
    chk({move_src_addr, 9'h0}, {12'h123, 9'h0});
    chk(21'(move_dst_addr), 21'h456);
    go(16'hfabc, 1'b0);
    chk(21'(dec_nop), 21'h1);
    go(16'h0e7f, 1'b0);
    chk({literal_width, 19'(literal_value)}, {2'h1, 19'h7f});
    go(16'hee2a, 1'b0);
    go(16'hf0bc, 1'b0);
    chk({literal_width, 19'(literal_value)}, {2'h2, 19'habc});
    chk(21'(ptr_sel), 21'h2);
    go(16'hef45, 1'b0);
    go(16'hf123, 1'b0);
    chk(branch_target, 21'h2468a);
    chk(21'(literal_value), 21'h12345);
    @(posedge clock);
    pc_value <= 21'h200;
    go(16'hd7ff, 1'b0);
    chk(branch_target, 21'h200);
    go(16'he280, 1'b0);
    chk({branch_valid, branch_target}, {1'b1, 21'h102});
  endtask
  task automatic t_table();
    logic [20:0] p, e;
    logic [7:0]  lat;
    p = 21'h1000;
    lat = 8'h00;
    wb(1'b1, 32'h04, 32'h1000);
    // Four reads, then four writes; writes leave the latch alone
    for (int m = 0; m < 8; m++) begin
      go({13'h0001, 3'(m)}, 1'b0);
      e = (m[1:0] == 2'h3) ? p + 21'h1 : p;
      p = (m[1:0] == 2'h2) ? p - 21'h1 : ((m[1:0] == 2'h0) ? p : p + 21'h1);
      if (m < 4) lat = e[7:0] ^ 8'h5a;
      chk({table_access, table_write, 19'h0}, {1'b1, m[2], 19'h0});
      chk(table_access_addr, e);
      wb(1'b0, 32'h04, 32'h0);
      chk(rd[20:0], p);
      wb(1'b0, 32'h08, 32'h0);
      chk(rd[20:0], 21'(lat));
      chk(21'(program_table_latch), 21'(lat));
    end
  endtask
  task automatic t_ctrl();
    logic [15:0] ws[4] = '{16'hed11, 16'h0013, 16'hec11, 16'h0012};
    for (int i = 0; i < 4; i++) begin
      go(ws[i], 1'b0);
      if (i[0] == 1'b0) go(16'hf000, 1'b0);
      chk({shadow_save, shadow_restore}, 21'(i < 2 ? (i == 0 ? 2 : 1) : 0));
    end
    wb(1'b1, 32'h14, 32'h200);
    go(16'heb05, 1'b0);
    go(16'hf123, 1'b0);
    chk(21'(indexed_src_addr), 21'h205);
    go(16'heb85, 1'b0);
    go(16'hf006, 1'b0);
    chk(21'(indexed_dst_addr), 21'h206);
    go(16'heb85, 1'b0);
    go(16'hff86, 1'b0);
    chk(21'(indexed_dst_addr), 21'h206);
    go(16'h2410, 1'b1);
    chk({dec_valid, dec_nop}, 21'h2);
    go(16'h2480, 1'b0);
    chk(21'(dec_nop), 21'h1);
    go(16'h2410, 1'b0);
    chk(21'(dec_nop), 21'h0);
  endtask
  initial begin
    repeat (20) @(posedge clock);
    chk(21'(dec_nop), 21'h1);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    t_regs();
    t_byte();
    t_bits();
    t_words();
    t_table();
    t_ctrl();
    finish_test();
  end
endmodule // tb_iod_decoder
`default_nettype wire
